// ===== src/hbb_pkg.sv
// Package for the host-bus bank decode register block.
// Holds offsets, field positions, reset values and burst codes.
// Assumes a 32-bit little-endian host bus with four byte enables.
package hbb_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses within the 16-byte window)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_BASE_ADDR = 4'h0;
  localparam logic [3:0] OFS_RX_WMARK  = 4'h4;
  localparam logic [3:0] OFS_BUS_ERR   = 4'h6;
  localparam logic [3:0] OFS_BURST_LEN = 4'h8;
  localparam logic [3:0] OFS_BANK_WORD = 4'hc;
  localparam logic [3:0] OFS_BANK_SEL  = 4'he;

  // ----------------------------------------------------------------
  // Bank numbers and field positions
  // ----------------------------------------------------------------
  localparam int         BANK_W        = 6;
  localparam int         NUM_BANKS     = 64;
  localparam logic [5:0] BANK_MAIN     = 6'h00;
  localparam int         BASE_HI_MSB   = 15;
  localparam int         BASE_LO_LSB   = 5;
  localparam int         WMARK_BIT     = 12;
  localparam int         BAD_LANE_FLAG = 15;
  localparam int         BAD_LANE_MSB  = 14;
  localparam int         BAD_LANE_LSB  = 11;
  localparam int         MIXED_FLAG    = 10;
  localparam int         BURST_MSB     = 14;
  localparam int         BURST_LSB     = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_RESET  = 16'h0300;
  localparam logic [5:0]  BANK_RESET  = 6'h00;
  localparam logic [2:0]  BURST_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Burst length codes and beat counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_FOUR   = 3'h3;
  localparam logic [2:0] BURST_EIGHT  = 3'h5;
  localparam logic [2:0] BURST_SIXTN  = 3'h7;
  localparam logic [4:0] BEATS_1      = 5'h01;
  localparam logic [4:0] BEATS_4      = 5'h04;
  localparam logic [4:0] BEATS_8      = 5'h08;
  localparam logic [4:0] BEATS_16     = 5'h10;

  // One host access, presented for a single cycle
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] wdata;
  } hbb_req_t;

endpackage : hbb_pkg

// ===== src/hbb_regs.sv
// Host-bus register front end: bank select, base-address decode,
// receive watermark choice, bus error latch and burst length.
// Assumes a host that presents one-cycle read or write strobes
// synchronous to clk_i, and an outside loader that offers the
// stored base address once after reset when an EEPROM is fitted.
//
// Functional notes
// - Six-bit bank selector, bits 5-0, resets zero.
// - Bank selector chooses among 64 register banks.
// - Bank select reachable from every bank.
// - Bank select at 0xC dword, 0xE word/byte.
// - Dword write at 0xC touches only 0xE.
// - Base bits 15-8 compared to address 15-8.
// - Base bits 7-5 compared; bits 4-0 read-only.
// - Base from EEPROM if present, else 0x300.
// - Software may rewrite base; EEPROM untouched.
// - Watermark bit 12: 0 is 3K, 1 is 2K.
// - Illegal byte enables set flag 15, W1C.
// - Offending enables stored in bits 14-11.
// - Simultaneous sync/async transfers set flag 10, W1C.
// - Burst field 14-12 decodes to 1/4/8/16.
// - Bank 1 reserved except bank select.
`timescale 1ns/1ns

module hbb_regs
  import hbb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire hbb_req_t          host_req_i,
  input  wire logic              sync_xfer_i,
  input  wire logic              async_xfer_i,
  input  wire logic              eeprom_present_pin_i,
  input  wire logic              eeprom_base_valid_i,
  input  wire logic [15:0]       eeprom_base_i,
  output logic [DATA_W-1:0]      host_rdata_o,
  output logic                   host_rvalid_o,
  output logic                   dev_hit_o,
  output logic [BANK_W-1:0]      bank_number_o,
  output logic [15:0]            base_addr_o,
  output logic                   rx_hiwater_2k_o,
  output logic [4:0]             burst_beats_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [BANK_W-1:0] bank_number_field_reg;
  logic [7:0]        base_upper_byte_reg;
  logic [2:0]        base_lower_bits_reg;
  logic              base_pending_reg;
  logic              wmark_reg;
  logic              bad_lane_select_flag_reg;
  logic [3:0]        bad_lane_select_value_reg;
  logic              mixed_transfer_flag_reg;
  logic [2:0]        burst_length_field_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              rvalid_reg;
  logic              hit_reg;
  logic [4:0]        beats_reg;
  logic [4:0]        beats_next;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       hit;
  logic       be_legal;
  logic       in_main_bank;
  logic [3:0] word_ofs;
  logic       wr_ok;
  logic       bad_be_event;
  logic       mixed_event;

  // Window match on base bits 15-5 with address bit 4 clear; bits 3-2 pick the word inside
  assign hit = (host_req_i.addr[15:8] == base_upper_byte_reg)
             && (host_req_i.addr[7:5] == base_lower_bits_reg)
             && !host_req_i.addr[4];
  assign word_ofs     = {host_req_i.addr[3:2], 2'b00};
  assign in_main_bank = (bank_number_field_reg == BANK_MAIN);

  // Single lanes, aligned halves and the full word are legal
  always_comb begin
    case (host_req_i.be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
      default:                                  be_legal = 1'b0;
    endcase
  end

  // Writes with a bad lane pattern are dropped, only logged
  assign wr_ok        = host_req_i.wr && hit && be_legal;
  assign bad_be_event = (host_req_i.rd || host_req_i.wr) && hit && !be_legal;
  assign mixed_event  = sync_xfer_i && async_xfer_i;

  // Write strobe for the bank-0 register words
  logic wr_main;
  assign wr_main = wr_ok && in_main_bank;

  // ----------------------------------------------------------------
  // Bank selector
  // ----------------------------------------------------------------
  // Lane 2 of word 0xC is the selector byte in every bank;
  // lanes 0-1 (0xC, 0xD) and lane 3 are reserved and ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_number_field_reg <= BANK_RESET;
    end else if (wr_ok && word_ofs == OFS_BANK_WORD && host_req_i.be[2]) begin
      bank_number_field_reg <= host_req_i.wdata[16 +: BANK_W];
    end
  end

  // ----------------------------------------------------------------
  // Base address
  // ----------------------------------------------------------------
  // Default comes first; a fitted EEPROM then overrides it once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_upper_byte_reg <= BASE_RESET[15:8];
      base_lower_bits_reg <= BASE_RESET[7:5];
      base_pending_reg    <= 1'b1;
    end else if (base_pending_reg) begin
      if (!eeprom_present_pin_i) begin
        base_pending_reg <= 1'b0;
      end else if (eeprom_base_valid_i) begin
        base_upper_byte_reg <= eeprom_base_i[15:8];
        base_lower_bits_reg <= eeprom_base_i[7:5];
        base_pending_reg    <= 1'b0;
      end
    end else if (wr_main && word_ofs == OFS_BASE_ADDR) begin
      // Decode value only; nothing flows back toward the EEPROM
      if (host_req_i.be[1]) begin
        base_upper_byte_reg <= host_req_i.wdata[15:8];
      end
      if (host_req_i.be[0]) begin
        base_lower_bits_reg <= host_req_i.wdata[7:5];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive watermark and burst length
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wmark_reg <= 1'b0;
    end else if (wr_main && word_ofs == OFS_RX_WMARK && host_req_i.be[1]) begin
      wmark_reg <= host_req_i.wdata[WMARK_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      burst_length_field_reg <= BURST_RESET;
    end else if (wr_main && word_ofs == OFS_BURST_LEN && host_req_i.be[1]) begin
      burst_length_field_reg <= host_req_i.wdata[BURST_MSB:BURST_LSB];
    end
  end

  // Unknown codes fall back to one beat, the safe choice
  always_comb begin
    case (burst_length_field_reg)
      BURST_FOUR:  beats_next = BEATS_4;
      BURST_EIGHT: beats_next = BEATS_8;
      BURST_SIXTN: beats_next = BEATS_16;
      default:     beats_next = BEATS_1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      beats_reg <= BEATS_1;
    end else begin
      beats_reg <= beats_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus error status
  // ----------------------------------------------------------------
  logic clr_hi;
  assign clr_hi = wr_main && word_ofs == OFS_RX_WMARK && host_req_i.be[3];

  // A new event in the clear cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_lane_select_flag_reg  <= 1'b0;
      bad_lane_select_value_reg <= 4'h0;
    end else if (bad_be_event) begin
      bad_lane_select_flag_reg  <= 1'b1;
      bad_lane_select_value_reg <= host_req_i.be;
    end else if (clr_hi && host_req_i.wdata[16 + BAD_LANE_FLAG]) begin
      bad_lane_select_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mixed_transfer_flag_reg <= 1'b0;
    end else if (mixed_event) begin
      mixed_transfer_flag_reg <= 1'b1;
    end else if (clr_hi && host_req_i.wdata[16 + MIXED_FLAG]) begin
      mixed_transfer_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Only bank 0 carries storage here; bank 1 and the rest read zero except the bank select word
  always_comb begin
    rdata_next = '0;
    if (in_main_bank) begin
      case (word_ofs)
        OFS_BASE_ADDR: begin
          rdata_next[15:0] = {base_upper_byte_reg, base_lower_bits_reg, 5'h00};
        end
        OFS_RX_WMARK: begin
          rdata_next[WMARK_BIT]               = wmark_reg;
          rdata_next[16 + BAD_LANE_FLAG]      = bad_lane_select_flag_reg;
          rdata_next[16 + BAD_LANE_MSB -: 4]  = bad_lane_select_value_reg;
          rdata_next[16 + MIXED_FLAG]         = mixed_transfer_flag_reg;
        end
        OFS_BURST_LEN: begin
          rdata_next[BURST_MSB:BURST_LSB] = burst_length_field_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
    if (word_ofs == OFS_BANK_WORD) begin
      rdata_next[16 +: BANK_W] = bank_number_field_reg;
    end
  end

  // Answer one cycle after the strobe, data held until next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      hit_reg    <= 1'b0;
    end else begin
      rvalid_reg <= host_req_i.rd && hit;
      hit_reg    <= (host_req_i.rd || host_req_i.wr) && hit;
      if (host_req_i.rd && hit) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign host_rdata_o    = rdata_reg;
  assign host_rvalid_o   = rvalid_reg;
  assign dev_hit_o       = hit_reg;
  assign bank_number_o   = bank_number_field_reg;
  assign base_addr_o     = {base_upper_byte_reg, base_lower_bits_reg, 5'h00};
  assign rx_hiwater_2k_o = wmark_reg;
  assign burst_beats_o   = beats_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bank_write_lands: assert property (
    (wr_ok && word_ofs == OFS_BANK_WORD && host_req_i.be[2])
      |=> bank_number_o == $past(host_req_i.wdata[21:16]))
    else $error("bank selector not updated by lane 2 write");

  a_bank_any_bank: assert property (
    (host_req_i.rd && hit && word_ofs == OFS_BANK_WORD)
      |=> host_rdata_o[21:16] == $past(bank_number_field_reg))
    else $error("bank selector unreadable from current bank");

  a_hit_decode: assert property (
    ((host_req_i.rd || host_req_i.wr) && host_req_i.addr[15:8] != base_upper_byte_reg)
      |=> !dev_hit_o)
    else $error("access outside base window was claimed");

  a_base_low_ro: assert property (
    base_addr_o[4:0] == 5'h00)
    else $error("reserved base bits not zero");

  a_bad_be_flag: assert property (
    bad_be_event |=> bad_lane_select_flag_reg && bad_lane_select_value_reg == $past(host_req_i.be))
    else $error("illegal byte enables not latched");

  a_mixed_sticky: assert property (
    mixed_event |=> mixed_transfer_flag_reg [*1] ##0 (mixed_transfer_flag_reg || $past(clr_hi)))
    else $error("mixed transfer flag not set");

  a_burst_decode: assert property (
    (burst_length_field_reg != BURST_FOUR && burst_length_field_reg != BURST_EIGHT
      && burst_length_field_reg != BURST_SIXTN && $stable(burst_length_field_reg))
      |=> burst_beats_o == BEATS_1)
    else $error("undefined burst code not single");

  a_bank1_zero: assert property (
    (host_req_i.rd && hit && !in_main_bank && word_ofs != OFS_BANK_WORD)
      |=> host_rdata_o == '0)
    else $error("reserved bank read not zero");

  a_wmark_write: assert property (
    (wr_main && word_ofs == OFS_RX_WMARK && host_req_i.be[1])
      |=> rx_hiwater_2k_o == $past(host_req_i.wdata[12]))
    else $error("watermark bit not written");

  a_bad_be_clear: assert property (
    (!bad_be_event && clr_hi && host_req_i.wdata[16 + BAD_LANE_FLAG])
      |=> !bad_lane_select_flag_reg)
    else $error("bad lane flag not cleared by write one");

  a_mixed_clear: assert property (
    (!mixed_event && clr_hi && host_req_i.wdata[16 + MIXED_FLAG])
      |=> !mixed_transfer_flag_reg)
    else $error("mixed transfer flag not cleared by write one");

  a_base_default: assert property (
    (base_pending_reg && !eeprom_present_pin_i)
      |=> base_addr_o == BASE_RESET)
    else $error("default base not kept without EEPROM");

  a_base_eeprom: assert property (
    (base_pending_reg && eeprom_present_pin_i && eeprom_base_valid_i)
      |=> base_addr_o == {$past(eeprom_base_i[15:5]), 5'h00})
    else $error("EEPROM base not loaded");

  a_burst_four: assert property (
    (burst_length_field_reg == BURST_FOUR) |=> burst_beats_o == BEATS_4)
    else $error("burst code four not decoded");

  a_bank1_ro: assert property (
    (wr_ok && !in_main_bank && word_ofs == OFS_RX_WMARK)
      |=> $stable(rx_hiwater_2k_o))
    else $error("reserved bank write reached watermark");

  c_bank_switch: cover property (wr_ok && word_ofs == OFS_BANK_WORD ##1 !in_main_bank);
  c_bad_be:      cover property (bad_be_event ##1 clr_hi);
  c_burst_16:    cover property (burst_beats_o == BEATS_16);
  c_eeprom_base: cover property (base_pending_reg && eeprom_base_valid_i && eeprom_present_pin_i);

endmodule : hbb_regs

// ===== testbench/hbb_host_model.sv
// Host CPU model for the host-bus register block.
// Assumes one clock shared with the block and one-cycle access strobes.
`timescale 1ns/1ns

module hbb_host_model
  import hbb_pkg::*;
(
  input  wire logic clk_i,
  output hbb_req_t  req_o
);
  initial req_o = '0;

  // Present one access just after an edge; the next edge samples it
  // Only intended bits are written and bursts are never started
  task automatic acc(input logic rd, input logic wr, input logic [15:0] addr,
                     input logic [3:0] be, input logic [31:0] wdata);
    @(posedge clk_i);
    #2;
    req_o = '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
  endtask : acc

  // Release: strobes low, other lines flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk_i);
    #2;
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~req_o.addr, be: ~req_o.be, wdata: ~req_o.wdata};
  endtask : idle
endmodule : hbb_host_model

// ===== testbench/testbench.sv
// Self-checking bench for the host-bus register block.
// Assumes the host model drives all accesses; reads are checked from a queue.
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end

module testbench
  import hbb_pkg::*;
();
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  hbb_req_t    host_req;
  logic        sync_x, async_x, ee_pin, ee_valid;
  logic [15:0] ee_base, base, cur_base;
  logic [31:0] rdata, exp_d;
  logic        rvalid, hit, wm;
  logic [5:0]  bank;
  logic [4:0]  beats;
  logic [15:0] lfsr_state = 16'd25689;
  logic [31:0] exp_q[$];
  logic [4:0]  beats_tab[8] = '{5'h01, 5'h01, 5'h01, 5'h04, 5'h01, 5'h08, 5'h01, 5'h10};
  int          n_fail = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #10 clk_i = ~clk_i;

  hbb_host_model host (.clk_i(clk_i), .req_o(host_req));

  hbb_regs dut (
    .clk_i(clk_i), .rst_i(rst_i), .host_req_i(host_req), .sync_xfer_i(sync_x),
    .async_xfer_i(async_x), .eeprom_present_pin_i(ee_pin), .eeprom_base_valid_i(ee_valid),
    .eeprom_base_i(ee_base), .host_rdata_o(rdata), .host_rvalid_o(rvalid), .dev_hit_o(hit),
    .bank_number_o(bank), .base_addr_o(base), .rx_hiwater_2k_o(wm), .burst_beats_o(beats)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic give_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] ofs, input logic [3:0] be, input logic [31:0] d);
    host.acc(1'b0, 1'b1, {cur_base[15:4], ofs}, be, d);
    host.idle();
  endtask : wr

  // Expected answer is noted before the access goes out
  task automatic rd(input logic [3:0] ofs, input logic [31:0] e);
    exp_q.push_back(e);
    host.acc(1'b1, 1'b0, {cur_base[15:4], ofs}, 4'hf, 32'h0000_0000);
    host.idle();
  endtask : rd

  // An access outside the window must stay silent
  task automatic miss(input logic [15:0] a);
    host.acc(1'b1, 1'b0, a, 4'hf, 32'h0000_0000);
    host.idle();
    @(negedge clk_i);
    `CHK(hit, 1'b0)
    `CHK(rvalid, 1'b0)
  endtask : miss

  // Read answers are popped in order; a stray answer counts as a mismatch
  always @(negedge clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("[ERR] %0t unexpected read answer", $time);
      end else begin
        exp_d = exp_q.pop_front();
        `CHK(rdata, exp_d)
      end
    end
  end

  // Hang guard, well above the roughly 140 cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [5:0]  v;
    sync_x = 1'b0; async_x = 1'b0; ee_pin = 1'b0; ee_valid = 1'b0;
    ee_base = 16'h0000; cur_base = 16'h0300;
    repeat (2) @(posedge clk_i);
    #2 rst_i = 1'b0;
    @(posedge clk_i);
    #2;
    `CHK(base, 16'h0300)
    `CHK(bank, 6'h00)
    `CHK(wm, 1'b0)
    `CHK(beats, 5'h01)
    rd(4'h0, 32'h0000_0300);
    rd(4'h4, 32'h0000_0000);
    rd(4'h8, 32'h0000_0000);
    rd(4'hc, 32'h0000_0000);
    // Rewrite the base; low bits are read-only
    wr(4'h0, 4'h3, 32'hffff_1a5f);
    cur_base = 16'h1a40;
    `CHK(base, 16'h1a40)
    miss(16'h030e);
    miss(16'h1b4e);
    miss(16'h1a0e);
    rd(4'h0, 32'h0000_1a40);
    wr(4'h4, 4'h3, 32'h0000_ffff);
    `CHK(wm, 1'b1)
    rd(4'h4, 32'h0000_1000);
    // Every burst code, reserved bits set in the write data
    for (int c = 0; c < 8; c++) begin
      wr(4'h8, 4'h3, {17'h0, c[2:0], 12'hfff});
      @(posedge clk_i);
      #2;
      `CHK(beats, beats_tab[c])
      rd(4'h8, {17'h0, c[2:0], 12'h000});
    end
    // Bank select through all three access forms, random banks
    for (int i = 0; i < 9; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      v = (i == 8) ? 6'h3f : lfsr_state[5:0];
      d = {lfsr_state, lfsr_state};
      d[21:16] = v;
      if (i % 3 == 0) wr(4'hc, 4'hf, d);
      else wr(4'he, (i % 3 == 1) ? 4'hc : 4'h4, d);
      @(negedge clk_i);
      `CHK(hit, 1'b1)
      `CHK(bank, v)
      rd(4'hc, {10'h000, v, 16'h0000});
    end
    // Bank 1 hides bank-0 registers
    wr(4'he, 4'h4, 32'h0001_0000);
    rd(4'h0, 32'h0000_0000);
    wr(4'h4, 4'h3, 32'h0000_0000);
    `CHK(wm, 1'b1)
    wr(4'he, 4'h4, 32'h0000_0000);
    `CHK(bank, 6'h00)
    // Illegal lane selects are dropped and latched, last one wins
    wr(4'h4, 4'h7, 32'h0000_0000);
    `CHK(wm, 1'b1)
    rd(4'h4, 32'hb800_1000);
    wr(4'h4, 4'h9, 32'h0000_0000);
    rd(4'h4, 32'hc800_1000);
    // One kind of transfer alone is normal; both together flag
    sync_x = 1'b1;
    rd(4'h4, 32'hc800_1000);
    async_x = 1'b1;
    @(posedge clk_i);
    #2 sync_x = 1'b0;
    async_x = 1'b0;
    rd(4'h4, 32'hcc00_1000);
    wr(4'h4, 4'h8, 32'h8400_0000);
    rd(4'h4, 32'h4800_1000);
    // Second reset with the EEPROM fitted
    ee_pin = 1'b1;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #2 rst_i = 1'b0;
    `CHK(wm, 1'b0)
    repeat (3) @(posedge clk_i);
    #2 ee_base = 16'h5cbf;
    ee_valid = 1'b1;
    @(posedge clk_i);
    #2 ee_valid = 1'b0;
    `CHK(base, 16'h5ca0)
    cur_base = 16'h5ca0;
    rd(4'h0, 32'h0000_5ca0);
    repeat (3) @(posedge clk_i);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule : testbench
